// File: cpu_exception_entry_unit.sv
// Purpose: Exception detection and entry for a 32-bit RISC core, with its status/cause registers on APB.
// Assumes: One instruction in the execute stage per cycle; bus error and interrupt pins are asynchronous.
// Notes: Entry completes in one cycle; the redirect is registered and lasts one cycle.
`timescale 1ns/1ps

module cpu_exception_entry_unit (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire exc_pkg::exec_req_t exReq,
    input wire logic busErr,
    input wire logic busReadActive,
    input wire logic busRefIsFetch,
    input wire logic [5:0] hwIntReq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output exc_pkg::redirect_t redirect,
    output logic curKernelUser,
    output logic irq
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [6:0] pinMeta_q;
    logic [6:0] pinSync_q;
    logic busErrSync;
    logic [5:0] hwPending;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinMeta_q <= 7'h00;
            pinSync_q <= 7'h00;
        end else begin
            pinMeta_q <= {busErr, hwIntReq};
            pinSync_q <= pinMeta_q;
        end
    end

    assign busErrSync = pinSync_q[6];
    // Hardware pending simply mirrors the request level; the source must hold it.
    assign hwPending = pinSync_q[5:0];

    // ************************************************************
    // Architectural state
    // ************************************************************
    logic [3:0] coprocUsable_q;
    logic [7:0] interrupt_mask_field_q;
    logic [5:0] kstack_q;
    logic delaySlot_q;
    logic [1:0] coprocErr_q;
    logic [1:0] swPending_q;
    logic [4:0] causeCode_q;
    logic [31:0] restartAddr_q;
    logic [31:0] vector_q;
    logic [6:0] evtStat_q;
    logic [6:0] evtMask_q;
    exc_pkg::redirect_t redirect_q;

    // ************************************************************
    // Instruction decode
    // ************************************************************
    logic [5:0] opc;
    logic [5:0] fnc;
    logic [1:0] cpNum;
    logic isSpecial;
    logic isCoproc;
    logic opDefined;
    logic fnDefined;

    assign opc = exReq.instr[31:26];
    assign fnc = exReq.instr[5:0];
    assign isSpecial = opc == exc_pkg::OP_SPECIAL;
    assign cpNum = opc[1:0];
    assign isCoproc = opc[5:2] == exc_pkg::OP_COPZ || opc[5:2] == exc_pkg::OP_LWCZ
                      || opc[5:2] == exc_pkg::OP_SWCZ;

    function automatic logic primaryDefined(input logic [5:0] op);
        unique case (op) inside
            [6'h00:6'h13], [6'h20:6'h26], [6'h28:6'h2B], 6'h2E, [6'h30:6'h33], [6'h38:6'h3B]: primaryDefined = 1'b1;
            default: primaryDefined = 1'b0;
        endcase
    endfunction

    function automatic logic specialDefined(input logic [5:0] fn);
        unique case (fn) inside
            6'h00, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0C, 6'h0D,
            [6'h10:6'h13], [6'h18:6'h1B], [6'h20:6'h27], 6'h2A, 6'h2B: specialDefined = 1'b1;
            default: specialDefined = 1'b0;
        endcase
    endfunction

    assign opDefined = primaryDefined(opc);
    assign fnDefined = specialDefined(fnc);

    // ************************************************************
    // Exception detection
    // ************************************************************
    logic reservedHit;
    logic breakHit;
    logic coprocHit;
    logic ovfHit;
    logic fetchBusHit;
    logic dataBusHit;
    logic intHit;
    logic [32:0] addSum;
    logic [32:0] subDiff;
    logic addOvf;
    logic subOvf;
    logic cpAllowed;
    logic [7:0] intPending;

    // Undefined primary opcode, or special class with undefined function.
    assign reservedHit = exReq.valid && (!opDefined || (isSpecial && !fnDefined));
    // Only opcode and function select the breakpoint; bits 25..6 are never looked at.
    assign breakHit = exReq.valid && isSpecial && fnc == exc_pkg::FN_BREAK;
    // System unit is always usable in kernel mode (kernel is a clear mode bit).
    assign cpAllowed = coprocUsable_q[cpNum] || (cpNum == 2'd0 && !kstack_q[1]);
    assign coprocHit = exReq.valid && isCoproc && !cpAllowed;

    assign addSum = {exReq.opA[31], exReq.opA} + {exReq.opB[31], exReq.opB};
    assign subDiff = {exReq.opA[31], exReq.opA} - {exReq.opB[31], exReq.opB};
    assign addOvf = addSum[32] != addSum[31];
    assign subOvf = subDiff[32] != subDiff[31];
    // Signed add, add-immediate and subtract overflow; the unsigned forms never trap.
    assign ovfHit = exReq.valid && (((isSpecial && fnc == exc_pkg::FN_ADD) || opc == exc_pkg::OP_ADDI) && addOvf
                    || (isSpecial && fnc == exc_pkg::FN_SUB) && subOvf);

    // Bus error counts only while a read reference is outstanding.
    assign fetchBusHit = busErrSync && busReadActive && busRefIsFetch;
    assign dataBusHit = busErrSync && busReadActive && !busRefIsFetch;

    // Eight sources: two software, six hardware, each masked, all gated by current enable.
    assign intPending = {hwPending, swPending_q};
    assign intHit = exReq.valid && kstack_q[0] && |(intPending & interrupt_mask_field_q);

    // ************************************************************
    // Priority and cause selection
    // ************************************************************
    // Synchronous faults outrank interrupts, which are the only maskable entry.
    logic takeExc;
    logic [4:0] selCode;
    logic [6:0] evtSet;

    always_comb begin
        selCode = exc_pkg::interrupt_code;
        evtSet = 7'h00;
        if (fetchBusHit) begin
            selCode = exc_pkg::fetch_bus_err_code;
            evtSet[exc_pkg::EV_FBE] = 1'b1;
        end else if (dataBusHit) begin
            selCode = exc_pkg::data_bus_err_code;
            evtSet[exc_pkg::EV_DBE] = 1'b1;
        end else if (reservedHit) begin
            selCode = exc_pkg::reserved_instr_code;
            evtSet[exc_pkg::EV_RSV] = 1'b1;
        end else if (coprocHit) begin
            selCode = exc_pkg::coproc_unusable_code;
            evtSet[exc_pkg::EV_CPU] = 1'b1;
        end else if (breakHit) begin
            selCode = exc_pkg::breakpoint_code;
            evtSet[exc_pkg::EV_BRK] = 1'b1;
        end else if (ovfHit) begin
            selCode = exc_pkg::overflow_code;
            evtSet[exc_pkg::EV_OVF] = 1'b1;
        end else if (intHit) begin
            selCode = exc_pkg::interrupt_code;
            evtSet[exc_pkg::EV_INT] = 1'b1;
        end
    end

    assign takeExc = |evtSet;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic apbSetup;
    logic apbWrite;
    logic hitStatus;
    logic hitCause;
    logic hitRestart;
    logic hitVector;
    logic hitEvtStat;
    logic hitEvtMask;
    logic mapped;
    logic [31:0] statusView;
    logic [31:0] causeView;
    logic [31:0] readMux;

    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    assign hitStatus = paddr == {24'h000000, exc_pkg::OFS_STATUS};
    assign hitCause = paddr == {24'h000000, exc_pkg::OFS_CAUSE};
    assign hitRestart = paddr == {24'h000000, exc_pkg::OFS_RESTART};
    assign hitVector = paddr == {24'h000000, exc_pkg::OFS_VECTOR};
    assign hitEvtStat = paddr == {24'h000000, exc_pkg::OFS_EVT_STAT};
    assign hitEvtMask = paddr == {24'h000000, exc_pkg::OFS_EVT_MASK};
    assign mapped = hitStatus || hitCause || hitRestart || hitVector || hitEvtStat || hitEvtMask;

    assign statusView = {coprocUsable_q, 12'h000, interrupt_mask_field_q, 2'b00, kstack_q};
    // Both pending fields are shown live; several bits may stand at once.
    assign causeView = {delaySlot_q, 1'b0, coprocErr_q, 12'h000, hwPending, swPending_q, 1'b0, causeCode_q, 2'b00};

    assign readMux = hitStatus ? statusView :
                     hitCause ? causeView :
                     hitRestart ? restartAddr_q :
                     hitVector ? vector_q :
                     hitEvtStat ? {25'h0000000, evtStat_q} :
                     hitEvtMask ? {25'h0000000, evtMask_q} : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (apbSetup && !pwrite) begin
            prdata <= readMux;
        end
    end

    // ************************************************************
    // Status register and mode stack
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            coprocUsable_q <= exc_pkg::CU_RST;
            interrupt_mask_field_q <= exc_pkg::IM_RST;
            kstack_q <= exc_pkg::KSTACK_RST;
        end else begin
            if (apbWrite && hitStatus) begin
                coprocUsable_q <= pwdata[exc_pkg::ST_CU_LSB +: 4];
                interrupt_mask_field_q <= pwdata[exc_pkg::ST_IM_LSB +: 8];
                kstack_q <= pwdata[5:0];
            end
            // Entry overrides a same-cycle software write to the stack.
            if (takeExc) begin
                kstack_q <= {kstack_q[3:0], 2'b00};
            end
        end
    end

    // ************************************************************
    // Cause, restart address and redirect
    // ************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            delaySlot_q <= 1'b0;
            coprocErr_q <= 2'b00;
            causeCode_q <= 5'h00;
            restartAddr_q <= 32'h00000000;
        end else if (takeExc) begin
            causeCode_q <= selCode;
            // Only the one referenced unit is reported; stale otherwise.
            if (evtSet[exc_pkg::EV_CPU]) begin
                coprocErr_q <= cpNum;
            end
            delaySlot_q <= exReq.inDelaySlot;
            restartAddr_q <= exReq.inDelaySlot ? exReq.branchPc : exReq.pc;
        end
    end

    // Software interrupt bits stay until software writes zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            swPending_q <= 2'b00;
        end else if (apbWrite && hitCause) begin
            swPending_q <= pwdata[exc_pkg::CA_SW_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            vector_q <= exc_pkg::GENERAL_VECTOR_RST;
        end else if (apbWrite && hitVector) begin
            vector_q <= pwdata;
        end
    end

    // Every exception kind lands on the same general vector.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            redirect_q <= '0;
        end else begin
            redirect_q.taken <= takeExc;
            redirect_q.target <= vector_q;
            redirect_q.code <= selCode;
        end
    end

    assign redirect = redirect_q;
    assign curKernelUser = kstack_q[1];

    // ************************************************************
    // Event status, mask and interrupt line
    // ************************************************************
    // Write one to clear; a same-cycle event keeps its bit set.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            evtStat_q <= 7'h00;
            evtMask_q <= exc_pkg::EVT_MASK_RST;
        end else begin
            evtStat_q <= (evtStat_q & ~((apbWrite && hitEvtStat) ? pwdata[6:0] : 7'h00)) | evtSet;
            if (apbWrite && hitEvtMask) begin
                evtMask_q <= pwdata[6:0];
            end
        end
    end

    assign irq = |(evtStat_q & evtMask_q);

endmodule

// File: exc_entry_chk.sv
// Purpose: Port-level assertions for the exception entry unit.
// Assumes: The caller drops a faulting instruction after the edge that takes it.
// Notes: Bus error checks allow for the two-stage pin synchroniser.
`timescale 1ns/1ps
module exc_entry_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire exc_pkg::exec_req_t exReq,
    input wire logic busErr,
    input wire logic busReadActive,
    input wire logic busRefIsFetch,
    input wire exc_pkg::redirect_t redirect,
    input wire logic curKernelUser,
    input wire logic irq
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    wire logic isSpec = exReq.valid && exReq.instr[31:26] == exc_pkg::OP_SPECIAL;
    wire logic [31:0] sumV = exReq.opA + exReq.opB;
    wire logic [31:0] difV = exReq.opA - exReq.opB;
    wire logic isAdd = (isSpec && exReq.instr[5:0] == exc_pkg::FN_ADD) ||
        (exReq.valid && exReq.instr[31:26] == exc_pkg::OP_ADDI);
    wire logic addOv = isAdd && exReq.opA[31] == exReq.opB[31] && sumV[31] != exReq.opA[31];
    wire logic subOv = isSpec && exReq.instr[5:0] == exc_pkg::FN_SUB && exReq.opA[31] != exReq.opB[31] &&
        difV[31] != exReq.opA[31];
    // A bus error outranks every instruction fault, so it may replace the expected code.
    wire logic busCode = redirect.code == exc_pkg::fetch_bus_err_code || redirect.code == exc_pkg::data_bus_err_code;

    a_break_entry: assert property (isSpec && exReq.instr[5:0] == exc_pkg::FN_BREAK |=>
        redirect.taken && (redirect.code == exc_pkg::breakpoint_code || busCode)) else $error("break not taken");
    a_reserved_entry: assert property (exReq.valid && exReq.instr[31:26] inside {[6'h14:6'h1F]} |=>
        redirect.taken && (redirect.code == exc_pkg::reserved_instr_code || busCode)) else $error("reserved missed");
    a_overflow_entry: assert property (addOv || subOv |=>
        redirect.taken && (redirect.code == exc_pkg::overflow_code || busCode)) else $error("overflow missed");
    a_entry_kernel: assert property (redirect.taken |-> !curKernelUser) else $error("user mode kept");
    a_taken_cause: assert property (redirect.taken |-> $past(exReq.valid) || $past(busReadActive))
        else $error("redirect without cause");
    a_taken_pulse: assert property (redirect.taken && !exReq.valid && !busReadActive |=> !redirect.taken)
        else $error("redirect too long");
    a_fetch_buserr: assert property ((busErr && busReadActive && busRefIsFetch) [*3] |=>
        redirect.taken && redirect.code == exc_pkg::fetch_bus_err_code) else $error("fetch bus error missed");
    a_data_buserr: assert property ((busErr && busReadActive && !busRefIsFetch) [*3] |=>
        redirect.taken && redirect.code == exc_pkg::data_bus_err_code) else $error("data bus error missed");
    c_break: cover property (redirect.taken && redirect.code == exc_pkg::breakpoint_code);
    c_intr: cover property (redirect.taken && redirect.code == exc_pkg::interrupt_code);
    c_irq: cover property ($rose(irq));
endmodule

bind cpu_exception_entry_unit exc_entry_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .exReq(exReq),
    .busErr(busErr), .busReadActive(busReadActive), .busRefIsFetch(busRefIsFetch), .redirect(redirect),
    .curKernelUser(curKernelUser), .irq(irq));

// File: exc_pkg.sv
// Purpose: Shared constants and types of the exception entry unit.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes: Cause codes follow the customary five-bit encodings.
package exc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_RESTART = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h0C;
    localparam logic [7:0] OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK = 8'h14;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int ST_CU_LSB = 28;
    localparam int ST_IM_LSB = 8;
    localparam int CA_BD_BIT = 31;
    localparam int CA_CE_LSB = 28;
    localparam int CA_HW_LSB = 10;
    localparam int CA_SW_LSB = 8;
    localparam int CA_CODE_LSB = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] GENERAL_VECTOR_RST = 32'h80000080;
    localparam logic [3:0] CU_RST = 4'h0;
    localparam logic [7:0] IM_RST = 8'h00;
    localparam logic [5:0] KSTACK_RST = 6'h00;
    localparam logic [6:0] EVT_MASK_RST = 7'h00;

    // ************************************************************
    // Cause codes
    // ************************************************************
    localparam logic [4:0] interrupt_code = 5'h00;
    localparam logic [4:0] fetch_bus_err_code = 5'h06;
    localparam logic [4:0] data_bus_err_code = 5'h07;
    localparam logic [4:0] breakpoint_code = 5'h09;
    localparam logic [4:0] reserved_instr_code = 5'h0A;
    localparam logic [4:0] coproc_unusable_code = 5'h0B;
    localparam logic [4:0] overflow_code = 5'h0C;

    // Event status bit positions.
    localparam int EV_INT = 0;
    localparam int EV_FBE = 1;
    localparam int EV_DBE = 2;
    localparam int EV_BRK = 3;
    localparam int EV_RSV = 4;
    localparam int EV_CPU = 5;
    localparam int EV_OVF = 6;

    // Instruction encodings.
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_ADDI = 6'h08;
    localparam logic [5:0] FN_BREAK = 6'h0D;
    localparam logic [5:0] FN_ADD = 6'h20;
    localparam logic [5:0] FN_SUB = 6'h22;
    localparam logic [3:0] OP_COPZ = 4'h4;
    localparam logic [3:0] OP_LWCZ = 4'hC;
    localparam logic [3:0] OP_SWCZ = 4'hE;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] pc;
        logic inDelaySlot;
        logic [31:0] branchPc;
        logic [31:0] opA;
        logic [31:0] opB;
    } exec_req_t;

    typedef struct packed {
        logic taken;
        logic [31:0] target;
        logic [4:0] code;
    } redirect_t;

endpackage

// File: ext_bus_model.sv
// Purpose: Far side of the unit: external read logic and hardware interrupt sources.
// Assumes: Called by the bench just after a rising clock edge.
// Notes: The reference kind line is noise outside a read, so nothing may trust it there.
`timescale 1ns/1ps
module ext_bus_model (
    input wire logic clk_sys,
    output logic busErr,
    output logic busReadActive,
    output logic busRefIsFetch,
    output logic [5:0] hwIntReq
);
    // ********
    // Reference and interrupt drivers
    // ********
    logic kindQ = 1'b0;
    logic noiseQ = 1'b0;
    initial begin
        busErr = 1'b0;
        busReadActive = 1'b0;
        hwIntReq = 6'h00;
    end
    always @(posedge clk_sys) begin
        noiseQ <= ~noiseQ;
    end
    assign busRefIsFetch = busReadActive ? kindQ : noiseQ;
    // Errors of buffered writes never reach this pin, only reads can fail here.
    task automatic readRef(input logic fetch, input logic fail, input int len);
        busReadActive <= 1'b1;
        kindQ <= fetch;
        busErr <= fail;
        repeat (len) @(posedge clk_sys);
        busReadActive <= 1'b0;
        busErr <= 1'b0;
    endtask
    // A source keeps its level until the cause is removed.
    task automatic setIrq(input logic [5:0] lvl);
        hwIntReq <= lvl;
    endtask
endmodule

// File: tb.sv
// Purpose: Self-checking bench of the exception entry unit.
// Assumes: Zero-wait APB slave; vector and event registers as the package maps them.
// Notes: Status and cause are modelled by the bench and compared after each entry.
`timescale 1ns/1ps
module tb;
    // ********
    // Signals and model state
    // ********
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    exc_pkg::exec_req_t exReq = '0;
    logic busErr, busReadActive, busRefIsFetch, pready, pslverr, curKernelUser, irq, serr;
    logic [5:0] hwIntReq;
    logic [31:0] prdata, rd, vec;
    exc_pkg::redirect_t redirect;
    logic [31:0] mStat = 32'h0;
    logic [1:0] mSw = 2'h0;
    logic [1:0] mCe = 2'h0;
    logic [5:0] rsvOp [10] = '{6'h14, 6'h1F, 6'h27, 6'h2C, 6'h2D, 6'h2F, 6'h34, 6'h37, 6'h3C, 6'h3F};
    logic [5:0] rsvFn [4] = '{6'h01, 6'h05, 6'h0E, 6'h3F};
    int errCount = 0;
    int checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    cpu_exception_entry_unit u_cpu_exception_entry_unit (.clk_sys(clk_sys), .resetn(resetn), .exReq(exReq),
        .busErr(busErr), .busReadActive(busReadActive), .busRefIsFetch(busRefIsFetch), .hwIntReq(hwIntReq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .redirect(redirect), .curKernelUser(curKernelUser), .irq(irq));
    ext_bus_model u_ext (.clk_sys(clk_sys), .busErr(busErr), .busReadActive(busReadActive),
        .busRefIsFetch(busRefIsFetch), .hwIntReq(hwIntReq));

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One idle cycle follows each transfer, so back-to-back calls never drive psel twice at one edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wst(input logic [31:0] v);
        apb(1'b1, exc_pkg::OFS_STATUS, v);
        mStat = v & 32'hF000FF3F;
    endtask
    task automatic entry(input logic [4:0] code, input int ev, input logic [31:0] rpc, input logic bd);
        @(posedge clk_sys);
        chk(redirect.taken, ev >= 0);
        if (ev >= 0) begin
            chk(redirect.target, vec);
            chk(redirect.code, code);
            chk(irq, 1'b1);
            chk(curKernelUser, 1'b0);
            mStat[5:0] = {mStat[3:0], 2'b00};
            apb(1'b0, exc_pkg::OFS_CAUSE, 32'h0);
            chk(rd & 32'hB000FF7C, {bd, 1'b0, mCe, 12'h000, hwIntReq, mSw, 1'b0, code, 2'b00});
            apb(1'b0, exc_pkg::OFS_RESTART, 32'h0);
            chk(rd, rpc);
            apb(1'b0, exc_pkg::OFS_STATUS, 32'h0);
            chk(rd & 32'hF000FF3F, mStat);
            apb(1'b0, exc_pkg::OFS_EVT_STAT, 32'h0);
            chk(rd, 32'h1 << ev);
            apb(1'b1, exc_pkg::OFS_EVT_STAT, 32'h7F);
            chk(irq, 1'b0);
        end
    endtask
    task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                       input logic [4:0] code, input int ev);
        logic [31:0] pc;
        logic ds;
        pc = $urandom & 32'hFFFFFFFC;
        ds = 1'($urandom);
        exReq <= '{1'b1, ins, pc, ds, pc - 32'h4, a, b};
        @(posedge clk_sys);
        exReq.valid <= 1'b0;
        entry(code, ev, ds ? pc - 32'h4 : pc, ds);
    endtask
    function automatic bit ovf(input bit sub, input logic [31:0] a, input logic [31:0] b);
        longint r;
        r = sub ? longint'($signed(a)) - longint'($signed(b)) : longint'($signed(a)) + longint'($signed(b));
        return r > 64'sh7FFFFFFF || r < -64'sh80000000;
    endfunction

    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        summarize();
    end
    initial begin
        logic [31:0] a, b;
        logic [5:0] hw;
        int k;
        void'($urandom(30847));
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, exc_pkg::OFS_VECTOR, 32'h0);
        chk(rd, exc_pkg::GENERAL_VECTOR_RST);
        apb(1'b0, exc_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'hF000FF3F, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(serr, 1'b1);
        vec = $urandom & 32'hFFFFFFFC;
        apb(1'b1, exc_pkg::OFS_VECTOR, vec);
        apb(1'b1, exc_pkg::OFS_EVT_MASK, 32'h7F);
        for (int i = 0; i < 3; i++) begin
            wst({26'h0, 6'($urandom)});
            run({6'h00, 20'($urandom), exc_pkg::FN_BREAK}, 32'h0, 32'h0, exc_pkg::breakpoint_code, exc_pkg::EV_BRK);
        end
        foreach (rsvOp[i]) run({rsvOp[i], 26'($urandom)}, 32'h0, 32'h0, exc_pkg::reserved_instr_code, exc_pkg::EV_RSV);
        foreach (rsvFn[i]) run({6'h00, 20'($urandom), rsvFn[i]}, 32'h0, 32'h0, exc_pkg::reserved_instr_code, exc_pkg::EV_RSV);
        wst(32'h20000002);
        run({exc_pkg::OP_COPZ, 28'h0}, 32'h0, 32'h0, exc_pkg::coproc_unusable_code, exc_pkg::EV_CPU);
        run({exc_pkg::OP_COPZ, 28'h0}, 32'h0, 32'h0, exc_pkg::coproc_unusable_code, -1);
        run({exc_pkg::OP_COPZ, 2'h1, 26'h0}, 32'h0, 32'h0, exc_pkg::coproc_unusable_code, -1);
        for (int z = 2; z < 4; z++) begin
            mCe = 2'(z);
            run({exc_pkg::OP_COPZ, mCe, 26'h0}, 32'h0, 32'h0, exc_pkg::coproc_unusable_code, exc_pkg::EV_CPU);
        end
        for (int i = 0; i < 12; i++) begin
            k = i % 4;
            a = {i[0] ? 17'h0FFFF : 17'h10000, 15'($urandom)};
            b = $urandom;
            if (k == 2) begin
                b = {{16{b[15]}}, b[15:0]};
            end
            run(k == 2 ? {exc_pkg::OP_ADDI, 10'($urandom), b[15:0]} : {6'h00, 15'($urandom), 5'h00,
                k == 0 ? exc_pkg::FN_ADD : k == 1 ? exc_pkg::FN_SUB : 6'h21}, a, b, exc_pkg::overflow_code,
                (k < 3 && ovf(k == 1, a, b)) ? exc_pkg::EV_OVF : -1);
        end
        for (int j = 0; j < 8; j++) begin
            hw = 6'($urandom);
            mSw = j < 2 ? 2'(1 << j) : 2'h0;
            if (j >= 2) begin
                hw[j - 2] = 1'b1;
            end
            u_ext.setIrq(j < 2 ? 6'h00 : hw);
            apb(1'b1, exc_pkg::OFS_CAUSE, {22'h0, mSw, 8'h00});
            wst(32'h00000001);
            run(32'h0, 32'h0, 32'h0, exc_pkg::interrupt_code, -1);
            wst(32'h00000001 | (32'h100 << j));
            run(32'h0, 32'h0, 32'h0, exc_pkg::interrupt_code, exc_pkg::EV_INT);
            run(32'h0, 32'h0, 32'h0, exc_pkg::interrupt_code, -1);
            mSw = 2'h0;
            u_ext.setIrq(6'h00);
            apb(1'b1, exc_pkg::OFS_CAUSE, 32'h0);
            apb(1'b0, exc_pkg::OFS_CAUSE, 32'h0);
            chk(rd[9:8], 2'h0);
        end
        exReq <= '{1'b0, 32'h0, 32'h00400100, 1'b0, 32'h0, 32'h0, 32'h0};
        u_ext.readRef(1'b1, 1'b0, 5);
        entry(exc_pkg::fetch_bus_err_code, -1, 32'h00400100, 1'b0);
        for (int f = 0; f < 2; f++) begin
            u_ext.readRef(f[0], 1'b1, 3);
            entry(f ? exc_pkg::fetch_bus_err_code : exc_pkg::data_bus_err_code,
                  f ? exc_pkg::EV_FBE : exc_pkg::EV_DBE, 32'h00400100, 1'b0);
        end
        summarize();
    end
endmodule
